// >>> rtl/igv_ctrl.sv
`timescale 1ns/1ps
module igv_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [1:0] phase,
  input wire logic ext_pin,
  input wire logic timer0_overflow,
  input wire logic port_change,
  input wire logic [7:0] peripheral_irq_flags_1_events,
  input wire logic [7:0] peripheral_irq_flags_2_events,
  input wire logic return_from_isr_instr,
  input wire logic sleeping,
  output logic wake,
  output logic core_flush,
  output logic core_push,
  output logic core_pop,
  output logic core_load_pc,
  output logic [12:0] core_pc_value,
  output logic irq
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    igv_pkg::igv_state_t fsm;
    logic [7:0] options;
    logic [7:0] peripheral_irq_enables_1;
    logic [7:0] peripheral_irq_enables_2;
    logic [7:0] core_irq_control;
    logic [7:0] peripheral_irq_flags_1;
    logic [7:0] peripheral_irq_flags_2;
    logic [3:0] cnt;
    logic [7:0] rdata;
    logic [2:0] ev_status;
    logic [2:0] ev_enable;
    igv_pkg::igv_core_cmd_t cmd;
    logic wake;
  } igv_ctrl_state_t;

  igv_ctrl_state_t st_q;
  igv_ctrl_state_t st_d;
  igv_pkg::igv_bus_req_t req;
  igv_pkg::igv_events_t ev;
  logic pin_pulse;
  logic ext_pin_irq_flag_set;
  logic [7:0] pend_core;
  logic [7:0] pend_p1;
  logic [7:0] pend_p2;
  logic pending;
  logic [7:0] ev_core;
  logic [7:0] wr_core;
  logic [3:0] lat_cycles;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Pin path: synchronised, edge selected by the option register.
  igv_edge_detect u_edge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin(ext_pin),
    .rising(st_q.options[igv_pkg::OPT_EDGE]),
    .pulse(pin_pulse)
  );

  // ************************************************************
  // Event collection
  // ************************************************************
  // The pin flag may only set in phases four and one, so an edge seen in
  // phases two or three is held in the flag logic until phase four.
  logic pin_hold_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_hold_q <= 1'b0;
    end else begin
      pin_hold_q <= (pin_hold_q | pin_pulse) & ~ext_pin_irq_flag_set;
    end
  end
  assign ext_pin_irq_flag_set = (pin_hold_q | pin_pulse) &
                                (phase == 2'd3 || phase == 2'd0);

  always_comb begin
    ev_core = 8'h00;
    ev_core[igv_pkg::CC_T0IF] = timer0_overflow;
    ev_core[igv_pkg::CC_EXT_PIN_IRQ_FLAG] = ext_pin_irq_flag_set;
    ev_core[igv_pkg::CC_RBIF] = port_change;
  end
  assign ev = '{core_src: ev_core, peripheral_irq_flags_1_src: peripheral_irq_flags_1_events, peripheral_irq_flags_2_src: peripheral_irq_flags_2_events};

  // Pending sources: each flag gated by its own enable.
  assign pend_core = {5'b0, st_q.core_irq_control[igv_pkg::CC_T0IE:igv_pkg::CC_RBIE]} &
                     {5'b0, st_q.core_irq_control[igv_pkg::CC_T0IF:igv_pkg::CC_RBIF]};
  assign pend_p1 = st_q.peripheral_irq_enables_1 & st_q.peripheral_irq_flags_1;
  assign pend_p2 = st_q.peripheral_irq_enables_2 & st_q.peripheral_irq_flags_2;
  assign pending = st_q.core_irq_control[igv_pkg::CC_GIE] &
                   ((|pend_core) |
                    (st_q.core_irq_control[igv_pkg::CC_PERIPHERAL_IRQ_GATE] & |(pend_p1 | pend_p2)));

  // Latency counted in phases; the core executes at the vector once the
  // count expires, independent of the instruction length in flight.
  assign lat_cycles = 4'((igv_pkg::LATENCY_TCY - 1) * igv_pkg::PHASES_PER_TCY);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    st_d = st_q;
    st_d.cmd = '0;
    st_d.wake = 1'b0;
    st_d.rdata = 8'h00;
    wr_core = req.wdata;

    // Software writes; flag bits are written then events OR in on top.
    if (req.wr) begin
      unique case (req.addr)
        igv_pkg::OFS_OPTIONS: st_d.options = req.wdata;
        igv_pkg::OFS_PERIPHERAL_IRQ_ENABLES_1: st_d.peripheral_irq_enables_1 = req.wdata;
        igv_pkg::OFS_PERIPHERAL_IRQ_ENABLES_2: st_d.peripheral_irq_enables_2 = req.wdata & igv_pkg::PERIPHERAL_IRQ_ENABLES_2_IMPL_MASK;
        igv_pkg::OFS_CORE_CTRL: st_d.core_irq_control = wr_core;
        igv_pkg::OFS_PERIPHERAL_IRQ_FLAGS_1: st_d.peripheral_irq_flags_1 = req.wdata;
        igv_pkg::OFS_PERIPHERAL_IRQ_FLAGS_2: st_d.peripheral_irq_flags_2 = req.wdata & igv_pkg::PERIPHERAL_IRQ_ENABLES_2_IMPL_MASK;
        igv_pkg::OFS_IRQ_CLEAR: st_d.ev_status = st_q.ev_status & ~req.wdata[2:0];
        igv_pkg::OFS_IRQ_ENABLE: st_d.ev_enable = req.wdata[2:0];
        default: ;
      endcase
    end

    // Events set flags regardless of enables and win over a clear.
    st_d.core_irq_control = st_d.core_irq_control | ev.core_src;
    st_d.peripheral_irq_flags_1 = st_d.peripheral_irq_flags_1 | ev.peripheral_irq_flags_1_src;
    st_d.peripheral_irq_flags_2 = st_d.peripheral_irq_flags_2 | (ev.peripheral_irq_flags_2_src & igv_pkg::PERIPHERAL_IRQ_ENABLES_2_IMPL_MASK);

    // Wake from sleep on any enabled core flag, or enabled peripheral flag with the peripheral gate set, even with global enable clear.
    if (sleeping && ((|pend_core) ||
        (st_q.core_irq_control[igv_pkg::CC_PERIPHERAL_IRQ_GATE] && |(pend_p1 | pend_p2)))) begin
      st_d.wake = 1'b1;
      st_d.ev_status[igv_pkg::EV_WAKE] = 1'b1;
    end

    unique case (st_q.fsm)
      igv_pkg::IGV_IDLE: begin
        // Sampled on phase one only; held back otherwise.
        if (pending && phase == 2'd0) begin
          st_d.fsm = igv_pkg::IGV_WAIT;
          st_d.cnt = lat_cycles;
          st_d.core_irq_control[igv_pkg::CC_GIE] = 1'b0;
          st_d.cmd.flush = 1'b1;
        end
      end
      igv_pkg::IGV_WAIT: begin
        if (st_q.cnt == 4'd1) begin
          st_d.fsm = igv_pkg::IGV_VECT;
        end
        st_d.cnt = st_q.cnt - 4'd1;
      end
      igv_pkg::IGV_VECT: begin
        // Push and vector together, also after a wake with enable set.
        st_d.cmd.push = 1'b1;
        st_d.cmd.load_pc = 1'b1;
        st_d.cmd.pc_value = igv_pkg::IRQ_VECTOR;
        st_d.ev_status[igv_pkg::EV_VECTOR] = 1'b1;
        st_d.fsm = igv_pkg::IGV_ISR;
      end
      igv_pkg::IGV_ISR: begin
        // Flags still set here retrigger after return, which is why
        // the service routine clears them first.
        if (return_from_isr_instr) begin
          st_d.cmd.pop = 1'b1;
          st_d.core_irq_control[igv_pkg::CC_GIE] = 1'b1;
          st_d.ev_status[igv_pkg::EV_RETURN] = 1'b1;
          st_d.fsm = igv_pkg::IGV_IDLE;
        end
      end
      default: st_d.fsm = igv_pkg::IGV_IDLE;
    endcase

    // Read data, one cycle after the strobe; reserved bits read zero.
    if (req.rd) begin
      unique case (req.addr)
        igv_pkg::OFS_OPTIONS: st_d.rdata = st_q.options;
        igv_pkg::OFS_PERIPHERAL_IRQ_ENABLES_1: st_d.rdata = st_q.peripheral_irq_enables_1;
        igv_pkg::OFS_PERIPHERAL_IRQ_ENABLES_2: st_d.rdata = st_q.peripheral_irq_enables_2;
        igv_pkg::OFS_CORE_CTRL: st_d.rdata = st_q.core_irq_control;
        igv_pkg::OFS_PERIPHERAL_IRQ_FLAGS_1: st_d.rdata = st_q.peripheral_irq_flags_1;
        igv_pkg::OFS_PERIPHERAL_IRQ_FLAGS_2: st_d.rdata = st_q.peripheral_irq_flags_2;
        igv_pkg::OFS_IRQ_STATUS: st_d.rdata = {5'b0, st_q.ev_status};
        igv_pkg::OFS_IRQ_ENABLE: st_d.rdata = {5'b0, st_q.ev_enable};
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Global enable is among the core control reset value, which is zero.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.fsm <= igv_pkg::IGV_IDLE;
      st_q.options <= igv_pkg::RST_OPTIONS;
      st_q.peripheral_irq_enables_1 <= igv_pkg::RST_PIE;
      st_q.peripheral_irq_enables_2 <= igv_pkg::RST_PIE;
      st_q.core_irq_control <= igv_pkg::RST_CORE_CTRL;
      st_q.peripheral_irq_flags_1 <= igv_pkg::RST_PIR;
      st_q.peripheral_irq_flags_2 <= igv_pkg::RST_PIR;
      st_q.cnt <= 4'd0;
      st_q.rdata <= 8'h00;
      st_q.ev_status <= 3'b000;
      st_q.ev_enable <= 3'b000;
      st_q.cmd <= '0;
      st_q.wake <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign wake = st_q.wake;
  assign core_flush = st_q.cmd.flush;
  assign core_push = st_q.cmd.push;
  assign core_pop = st_q.cmd.pop;
  assign core_load_pc = st_q.cmd.load_pc;
  assign core_pc_value = st_q.cmd.pc_value;
  assign irq = |(st_q.ev_status & st_q.ev_enable);

endmodule

// >>> rtl/igv_edge_detect.sv
`timescale 1ns/1ps
// Two-stage synchroniser with selectable edge detection for the pin event.
module igv_edge_detect (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic rising,
  output logic pulse
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } igv_sync_t;

  igv_sync_t st_q;
  igv_sync_t st_d;

  // Only the second and third stages feed the edge compare.
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pulse = rising ? (st_q.s2 & ~st_q.s3) : (~st_q.s2 & st_q.s3);

endmodule

// >>> rtl/igv_pkg.sv
package igv_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [8:0] OFS_OPTIONS = 9'h081;
  localparam logic [8:0] OFS_PERIPHERAL_IRQ_ENABLES_1 = 9'h08C;
  localparam logic [8:0] OFS_PERIPHERAL_IRQ_ENABLES_2 = 9'h08D;
  localparam logic [8:0] OFS_CORE_CTRL = 9'h00B;
  localparam logic [8:0] OFS_PERIPHERAL_IRQ_FLAGS_1 = 9'h00C;
  localparam logic [8:0] OFS_PERIPHERAL_IRQ_FLAGS_2 = 9'h00D;
  localparam logic [8:0] OFS_IRQ_STATUS = 9'h0F0;
  localparam logic [8:0] OFS_IRQ_CLEAR = 9'h0F1;
  localparam logic [8:0] OFS_IRQ_ENABLE = 9'h0F2;

  // ************************************************************
  // Reset values and field positions
  // ************************************************************
  localparam logic [7:0] RST_OPTIONS = 8'hFF;
  localparam logic [7:0] RST_PIE = 8'h00;
  localparam logic [7:0] RST_PIR = 8'h00;
  localparam logic [7:0] RST_CORE_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;
  localparam logic [7:0] PERIPHERAL_IRQ_ENABLES_2_IMPL_MASK = 8'hF1;
  localparam int CC_GIE = 7;
  localparam int CC_PERIPHERAL_IRQ_GATE = 6;
  localparam int CC_T0IE = 5;
  localparam int CC_INTE = 4;
  localparam int CC_RBIE = 3;
  localparam int CC_T0IF = 2;
  localparam int CC_EXT_PIN_IRQ_FLAG = 1;
  localparam int CC_RBIF = 0;
  localparam int OPT_EDGE = 6;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // ************************************************************
  // Timing: latency in instruction cycles, four phases each
  // ************************************************************
  localparam int LATENCY_TCY = 3;
  localparam int PHASES_PER_TCY = 4;

  // Status bits of the block's own interrupt output.
  localparam int EV_VECTOR = 0;
  localparam int EV_RETURN = 1;
  localparam int EV_WAKE = 2;

  typedef enum logic [3:0] {
    IGV_IDLE = 4'b0001,
    IGV_WAIT = 4'b0010,
    IGV_VECT = 4'b0100,
    IGV_ISR = 4'b1000
  } igv_state_t;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } igv_bus_req_t;

  typedef struct packed {
    logic [7:0] core_src;
    logic [7:0] peripheral_irq_flags_1_src;
    logic [7:0] peripheral_irq_flags_2_src;
  } igv_events_t;

  typedef struct packed {
    logic flush;
    logic push;
    logic pop;
    logic load_pc;
    logic [12:0] pc_value;
  } igv_core_cmd_t;

endpackage

// >>> tb/igv_core_model.sv
`timescale 1ns/1ps
// Core stand-in: phase sequencer and the return instruction pulse.
module igv_core_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ret_req,
  output logic [1:0] phase,
  output logic return_from_isr_instr
);
  // The phase only advances, so every fourth clock is a phase one sample.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
      return_from_isr_instr <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      return_from_isr_instr <= ret_req;
    end
  end
endmodule

// >>> tb/igv_ctrl_tb_top.sv
`timescale 1ns/1ps
module igv_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin = 1'b0;
  logic t0 = 1'b0;
  logic pc_ev = 1'b0;
  logic [7:0] p1 = 8'h00;
  logic [7:0] p2 = 8'h00;
  logic ret_req = 1'b0;
  logic slp = 1'b0;
  logic [7:0] rdata;
  logic [1:0] phase;
  logic ret, wake, flush, push, pop, load, irq;
  logic [12:0] pcv;
  int mismatches = 0;
  int check_count = 0;
  int flushes = 0;
  localparam int SYNC = igv_pkg::LATENCY_TCY * igv_pkg::PHASES_PER_TCY + 2;
  always #5 ref_clk = ~ref_clk;
  // Flushes counted off the sampling edge.
  always @(negedge ref_clk) if (flush === 1'b1) flushes++;
  igv_ctrl i_igv_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .phase(phase), .ext_pin(pin), .timer0_overflow(t0),
    .port_change(pc_ev), .peripheral_irq_flags_1_events(p1), .peripheral_irq_flags_2_events(p2), .return_from_isr_instr(ret),
    .sleeping(slp), .wake(wake), .core_flush(flush), .core_push(push), .core_pop(pop),
    .core_load_pc(load), .core_pc_value(pcv), .irq(irq));
  igv_core_model i_igv_core_model (.ref_clk(ref_clk), .rst_n(rst_n), .ret_req(ret_req),
    .phase(phase), .return_from_isr_instr(ret));
  // ****
  // Helpers
  // ****
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // The strobe drops a cycle before the next access may raise it.
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    chk(rdata === e, $sformatf("read %h gave %h", a, rdata));
    @(posedge ref_clk);
  endtask
  // Looks only at falling edges, so no output is read in the step that launches it.
  task automatic wait_load(input int lim);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (load !== 1'b1 && n < lim);
    chk(load === 1'b1, "vector late");
    chk(push === 1'b1 && pcv === igv_pkg::IRQ_VECTOR, "bad vector");
    @(posedge ref_clk);
  endtask
  task automatic no_vec(input int n);
    int f;
    f = flushes;
    repeat (n) @(posedge ref_clk);
    chk(flushes == f, "unexpected vector");
  endtask
  task automatic ret_isr;
    ret_req <= 1'b1;
    @(posedge ref_clk);
    ret_req <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(pop === 1'b1, "no pop");
    @(posedge ref_clk);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(negedge ref_clk);
    chk(irq === e, "irq level");
    @(posedge ref_clk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rd_chk(igv_pkg::OFS_OPTIONS, 8'hFF);
    rd_chk(igv_pkg::OFS_PERIPHERAL_IRQ_ENABLES_1, 8'h00);
    rd_chk(igv_pkg::OFS_CORE_CTRL, 8'h00);
    rd_chk(igv_pkg::OFS_PERIPHERAL_IRQ_FLAGS_1, 8'h00);
    rd_chk(9'h1FF, 8'h00);
  endtask
  // Unimplemented bits of the second pair stay zero for writes and events.
  task automatic t_gaps;
    wr_reg(igv_pkg::OFS_PERIPHERAL_IRQ_ENABLES_2, 8'hFF);
    rd_chk(igv_pkg::OFS_PERIPHERAL_IRQ_ENABLES_2, 8'hF1);
    p2 <= 8'hFF;
    @(posedge ref_clk);
    p2 <= 8'h00;
    @(posedge ref_clk);
    rd_chk(igv_pkg::OFS_PERIPHERAL_IRQ_FLAGS_2, 8'hF1);
    wr_reg(igv_pkg::OFS_PERIPHERAL_IRQ_FLAGS_2, 8'h00);
    rd_chk(igv_pkg::OFS_PERIPHERAL_IRQ_FLAGS_2, 8'h00);
    wr_reg(igv_pkg::OFS_PERIPHERAL_IRQ_ENABLES_2, 8'h00);
  endtask
  // Event recorded while masked, serviced once the global enable is set.
  task automatic t_core;
    wr_reg(igv_pkg::OFS_IRQ_ENABLE, 8'h01);
    t0 <= 1'b1;
    @(posedge ref_clk);
    t0 <= 1'b0;
    no_vec(20);
    rd_chk(igv_pkg::OFS_CORE_CTRL, 8'h04);
    wr_reg(igv_pkg::OFS_CORE_CTRL, 8'hA4);
    wait_load(SYNC + 3);
    rd_chk(igv_pkg::OFS_CORE_CTRL, 8'h24);
    irq_is(1'b1);
    wr_reg(igv_pkg::OFS_CORE_CTRL, 8'h20);
    ret_isr();
    rd_chk(igv_pkg::OFS_CORE_CTRL, 8'hA0);
    no_vec(20);
    rd_chk(igv_pkg::OFS_IRQ_STATUS, 8'h03);
    wr_reg(igv_pkg::OFS_IRQ_ENABLE, 8'h00);
    irq_is(1'b0);
    wr_reg(igv_pkg::OFS_IRQ_ENABLE, 8'h03);
    irq_is(1'b1);
    wr_reg(igv_pkg::OFS_IRQ_CLEAR, 8'h03);
    rd_chk(igv_pkg::OFS_IRQ_STATUS, 8'h00);
    irq_is(1'b0);
    t0 <= 1'b1;
    @(posedge ref_clk);
    t0 <= 1'b0;
    wait_load(SYNC);
    wr_reg(igv_pkg::OFS_CORE_CTRL, 8'h20);
    ret_isr();
  endtask
  // Peripheral sources also need the peripheral gate.
  task automatic t_periph;
    wr_reg(igv_pkg::OFS_PERIPHERAL_IRQ_ENABLES_1, 8'h01);
    wr_reg(igv_pkg::OFS_CORE_CTRL, 8'h80);
    p1 <= 8'h01;
    @(posedge ref_clk);
    p1 <= 8'h00;
    no_vec(20);
    wr_reg(igv_pkg::OFS_CORE_CTRL, 8'hC0);
    wait_load(SYNC + 3);
    wr_reg(igv_pkg::OFS_PERIPHERAL_IRQ_FLAGS_1, 8'h00);
    ret_isr();
    wr_reg(igv_pkg::OFS_PERIPHERAL_IRQ_ENABLES_1, 8'h00);
  endtask
  // Pin edge passes two synchroniser flops, hence the six extra cycles of slack.
  task automatic t_pin;
    wr_reg(igv_pkg::OFS_CORE_CTRL, 8'h90);
    pin <= 1'b1;
    @(posedge ref_clk);
    wait_load(SYNC + 6);
    rd_chk(igv_pkg::OFS_CORE_CTRL, 8'h12);
    wr_reg(igv_pkg::OFS_CORE_CTRL, 8'h10);
    ret_isr();
    // Falling edge selected next; the pin is high and steady, so no false edge.
    wr_reg(igv_pkg::OFS_OPTIONS, 8'hBF);
    pin <= 1'b0;
    @(posedge ref_clk);
    wait_load(SYNC + 6);
    rd_chk(igv_pkg::OFS_CORE_CTRL, 8'h12);
    wr_reg(igv_pkg::OFS_CORE_CTRL, 8'h10);
    ret_isr();
  endtask
  // Wake keeps its flag; vectoring follows only with the global enable.
  task automatic t_wake;
    int n;
    wr_reg(igv_pkg::OFS_CORE_CTRL, 8'h08);
    slp <= 1'b1;
    pc_ev <= 1'b1;
    @(posedge ref_clk);
    pc_ev <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (wake !== 1'b1 && n < 8);
    chk(wake === 1'b1, "no wake");
    @(posedge ref_clk);
    rd_chk(igv_pkg::OFS_CORE_CTRL, 8'h09);
    no_vec(12);
    wr_reg(igv_pkg::OFS_CORE_CTRL, 8'h89);
    wait_load(SYNC + 3);
    slp <= 1'b0;
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence after five cycles of reset.
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_gaps();
    t_core();
    t_periph();
    t_pin();
    t_wake();
    wrap_up();
  end
  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule
bind igv_ctrl igv_props i_igv_props (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .rd(rd),
  .rdata(rdata), .phase(phase), .return_from_isr_instr(return_from_isr_instr),
  .sleeping(sleeping), .wake(wake), .core_flush(core_flush), .core_push(core_push),
  .core_pop(core_pop), .core_load_pc(core_load_pc), .core_pc_value(core_pc_value));

// >>> tb/igv_props.sv
`timescale 1ns/1ps
module igv_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [8:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [1:0] phase,
  input wire logic return_from_isr_instr,
  input wire logic sleeping,
  input wire logic wake,
  input wire logic core_flush,
  input wire logic core_push,
  input wire logic core_pop,
  input wire logic core_load_pc,
  input wire logic [12:0] core_pc_value
);
  // ****
  // Vectoring, read and wake checks
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // The phase, push, pop and wake checks tie an output to the cause that must precede it.
  // The flush register leads the vector load by the full wait count plus the vector state.
  quiet_reset_a: assert property ($rose(rst_n) |-> !core_flush [*2]) else $error("early flush");
  flush_phase_a: assert property (core_flush |-> $past(phase) == 2'h0) else $error("bad phase");
  vector_load_a: assert property (core_flush |-> ##9 core_push && core_load_pc) else $error("no load");
  push_cause_a: assert property (core_push |-> $past(core_flush, 9)) else $error("stray push");
  vector_addr_a: assert property (core_load_pc |-> core_pc_value == 13'h0004) else $error("bad pc");
  gie_clear_a: assert property (core_flush |=> !core_flush [*8]) else $error("nested flush");
  pop_ret_a: assert property (core_pop |-> $past(return_from_isr_instr)) else $error("stray pop");
  gap_bits_a: assert property (rd && addr == 9'h08D |=> rdata[3:1] == 3'h0) else $error("gap set");
  wake_sleep_a: assert property (wake |-> $past(sleeping)) else $error("awake wake");
  // Main scenarios reached.
  cover property (core_push);
  cover property (core_pop);
  cover property (wake);
endmodule
